// ===== hdl/lsbf_exec.sv
// execution sequencer with APB register file for the logic, shift, bit and flow groups
//
// Chosen here: the register addresses and the APB slave port.
`timescale 1ns/1ps
module lsbf_exec import lsbf_pkg::*; (
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  lsbf_state_type state_ff;
  lsbf_op_type    op_ff;
  lsbf_form_type  form_ff;
  lsbf_cond_type  cond_ff;
  logic           dstw_ff;
  logic           two_ff;
  logic           exc_ff;
  logic [15:0]    opa_ff;
  logic [15:0]    opb_ff;
  logic [15:0]    lit_ff;
  logic [15:0]    word2_ff;
  logic [15:0]    freg_ff;
  logic [15:0]    dwreg_ff;
  logic [7:0]     flags_ff;
  logic [15:0]    result_ff;
  logic [15:0]    pc_ff;
  logic [15:0]    ret_ff;
  logic [1:0]     cycles_ff;
  logic           taken_ff;
  logic [14:0]    rpt_ff;
  logic [14:0]    rpt_left_ff;
  logic [1:0]     wait_ff;
  logic [14:0]    lp_cnt_ff;
  logic [15:0]    lp_start_ff;
  logic [15:0]    lp_end_ff;
  logic [31:0]    prdata_ff;
  logic           pready_ff;
  logic           pslverr_ff;

  logic           wr_acc;
  logic           go;
  logic           exec;
  logic           last;
  logic [15:0]    src_a;
  logic [15:0]    src_b;
  logic [3:0]     amt;
  logic [3:0]     bidx;
  logic [14:0]    count;
  logic [4:0]     scan_pos;
  lsbf_scan_type  scan_mode;
  logic [15:0]    alu_res;
  logic           alu_wr;
  logic           alu_c;
  logic           alu_z;
  logic           alu_n;
  logic           alu_v;
  logic           skip;
  logic           nxt_taken;
  logic [1:0]     nxt_cost;
  logic [15:0]    nxt_pc;
  logic           lp_back;
  logic [31:0]    rd_mux;

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------
  function automatic logic reg_hit(input logic [7:0] adr);
    reg_hit = adr inside {ADR_CTRL, ADR_OPA, ADR_OPB, ADR_LIT, ADR_WORD2, ADR_FREG,
                          ADR_DWREG, ADR_STAT, ADR_RESULT, ADR_PC, ADR_LOOP};
  endfunction : reg_hit

  function automatic logic cond_met(input lsbf_cond_type cc, input logic [7:0] f);
    logic c;
    logic z;
    logic n;
    logic v;
    c = f[FLG_C];
    z = f[FLG_Z];
    n = f[FLG_N];
    v = f[FLG_OV];
    case (cc)
      CC_ALW: cond_met = 1'b1;
      CC_C:   cond_met = c;
      CC_GE:  cond_met = (n == v);
      CC_GEU: cond_met = c;
      CC_GT:  cond_met = !z && (n == v);
      CC_GTU: cond_met = c && !z;
      CC_LE:  cond_met = z || (n != v);
      CC_LEU: cond_met = !c || z;
      CC_LT:  cond_met = (n != v);
      CC_LTU: cond_met = !c;
      CC_N:   cond_met = n;
      CC_NC:  cond_met = !c;
      CC_NN:  cond_met = !n;
      CC_NOV: cond_met = !v;
      CC_NZ:  cond_met = !z;
      CC_OA:  cond_met = f[FLG_OA];
      CC_OB:  cond_met = f[FLG_OB];
      CC_OV:  cond_met = v;
      CC_SA:  cond_met = f[FLG_SA];
      CC_SB:  cond_met = f[FLG_SB];
      CC_Z:   cond_met = z;
      default: cond_met = 1'b0;
    endcase
  endfunction : cond_met

  // ----------------------------------------------------------------
  // operand selection
  // ----------------------------------------------------------------
  assign wr_acc = psel && penable && pready_ff && pwrite && (state_ff == ST_IDLE);
  assign go     = wr_acc && (paddr == ADR_CTRL) && pwdata[CTL_GO];
  assign exec   = (state_ff == ST_EXEC);
  assign last   = exec && (rpt_left_ff <= 15'h0001);

  always_comb begin
    src_a = (form_ff == FORM_FILE) ? freg_ff : opa_ff;
    unique case (form_ff)
      FORM_FILE:  src_b = dwreg_ff;
      FORM_LIT10: src_b = {6'h00, lit_ff[9:0]};
      FORM_SHORT: src_b = {11'h000, lit_ff[4:0]};
      FORM_REG:   src_b = opb_ff;
    endcase
    amt   = (form_ff == FORM_SHORT) ? lit_ff[3:0] : (form_ff == FORM_REG) ? opb_ff[3:0] : 4'h1;
    bidx  = (form_ff == FORM_REG) ? opb_ff[3:0] : lit_ff[3:0];
    count = (form_ff == FORM_REG) ? opb_ff[14:0] : {1'b0, lit_ff[13:0]};
    scan_mode = (op_ff == OP_SONEL) ? SCAN_LSB1 : (op_ff == OP_SCHG) ? SCAN_SIGN : SCAN_MSB1;
  end

  lsbf_scan u_scan (
    .val  (src_a),
    .mode (scan_mode),
    .pos  (scan_pos)
  );

  lsbf_alu u_alu (
    .op       (op_ff),
    .a        (src_a),
    .b        (src_b),
    .amt      (amt),
    .bidx     (bidx),
    .scan_pos (scan_pos),
    .c_in     (flags_ff[FLG_C]),
    .z_in     (flags_ff[FLG_Z]),
    .res      (alu_res),
    .wr       (alu_wr),
    .c_out    (alu_c),
    .z_out    (alu_z),
    .n_out    (alu_n),
    .v_out    (alu_v)
  );

  // ----------------------------------------------------------------
  // flow decision: next pc and cycle cost
  // ----------------------------------------------------------------
  always_comb begin
    unique case (op_ff)
      OP_CSEQ: skip = alu_z;
      OP_CSGT: skip = !alu_z && (alu_n == alu_v);
      OP_CSLT: skip = (alu_n != alu_v);
      OP_CSNE: skip = !alu_z;
      OP_SKCL: skip = !src_a[bidx];
      OP_SKST: skip = src_a[bidx];
      default: skip = 1'b0;
    endcase
    nxt_taken = 1'b0;
    nxt_cost  = CYC_ONE;
    nxt_pc    = pc_ff + 16'h0001;
    unique case (op_ff)
      OP_CSEQ, OP_CSGT, OP_CSLT, OP_CSNE, OP_SKCL, OP_SKST: begin
        if (skip) begin
          nxt_taken = 1'b1;
          nxt_cost  = two_ff ? CYC_THREE : CYC_TWO;
          nxt_pc    = pc_ff + (two_ff ? 16'h0003 : 16'h0002);
        end
      end
      OP_BRA: begin
        if (cond_met(cond_ff, flags_ff)) begin
          nxt_taken = 1'b1;
          nxt_cost  = CYC_TWO;
          nxt_pc    = (form_ff == FORM_REG) ? opb_ff : pc_ff + 16'h0001 + lit_ff;
        end
      end
      OP_JMP, OP_CALL: begin
        nxt_taken = 1'b1;
        nxt_cost  = CYC_TWO;
        nxt_pc    = (form_ff == FORM_REG) ? opb_ff : word2_ff;
      end
      OP_RCALL: begin
        nxt_taken = 1'b1;
        nxt_cost  = CYC_TWO;
        nxt_pc    = pc_ff + 16'h0001 + ((form_ff == FORM_REG) ? opb_ff : lit_ff);
      end
      OP_LOOP: begin
        nxt_cost = CYC_TWO;
        nxt_pc   = pc_ff + 16'h0002;
      end
      OP_RET, OP_RETL, OP_RETI: begin
        nxt_taken = 1'b1;
        nxt_cost  = exc_ff ? CYC_TWO : CYC_THREE;
        nxt_pc    = ret_ff;
      end
      default: nxt_cost = CYC_ONE;
    endcase
    lp_back = !nxt_taken && (op_ff != OP_LOOP) && (pc_ff == lp_end_ff) && (lp_cnt_ff > 15'h0001);
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= ST_IDLE;
      wait_ff  <= 2'h0;
    end else begin
      unique case (state_ff)
        ST_IDLE: if (go) state_ff <= ST_EXEC;
        ST_EXEC: begin
          if (last) begin
            wait_ff  <= nxt_cost - CYC_ONE;
            state_ff <= (nxt_cost == CYC_ONE) ? ST_IDLE : ST_WAIT;
          end
        end
        ST_WAIT: begin
          wait_ff <= wait_ff - 2'h1;
          if (wait_ff == 2'h1) state_ff <= ST_IDLE;
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // single-instruction repeat: the next launched instruction runs count plus one times
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rpt_ff      <= RST_CNT;
      rpt_left_ff <= RST_CNT;
    end else if (go) begin
      rpt_left_ff <= (rpt_ff == RST_CNT) ? 15'h0001 : rpt_ff;
      rpt_ff      <= RST_CNT;
    end else if (exec) begin
      if (!last) rpt_left_ff <= rpt_left_ff - 15'h0001;
      if (last && op_ff == OP_RPT) rpt_ff <= count + 15'h0001;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pc_ff       <= RST_WORD;
      ret_ff      <= RST_WORD;
      cycles_ff   <= 2'h0;
      taken_ff    <= 1'b0;
      lp_cnt_ff   <= RST_CNT;
      lp_start_ff <= RST_WORD;
      lp_end_ff   <= RST_WORD;
    end else if (wr_acc && paddr == ADR_PC) begin
      pc_ff <= pwdata[15:0];
    end else if (last) begin
      cycles_ff <= nxt_cost;
      taken_ff  <= nxt_taken;
      pc_ff     <= lp_back ? lp_start_ff : nxt_pc;
      if (lp_back) lp_cnt_ff <= lp_cnt_ff - 15'h0001;
      else if (pc_ff == lp_end_ff && lp_cnt_ff != RST_CNT) lp_cnt_ff <= RST_CNT;
      if (op_ff == OP_CALL) ret_ff <= pc_ff + ((form_ff == FORM_REG) ? 16'h0001 : 16'h0002);
      if (op_ff == OP_RCALL) ret_ff <= pc_ff + 16'h0001;
      if (op_ff == OP_LOOP) begin
        lp_cnt_ff   <= count + 15'h0001;
        lp_start_ff <= pc_ff + 16'h0002;
        lp_end_ff   <= pc_ff + word2_ff;
      end
    end
  end

  // ----------------------------------------------------------------
  // instruction and operand registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      op_ff    <= OP_NOP;
      form_ff  <= FORM_FILE;
      cond_ff  <= CC_ALW;
      dstw_ff  <= 1'b0;
      two_ff   <= 1'b0;
      exc_ff   <= 1'b0;
      opa_ff   <= RST_WORD;
      opb_ff   <= RST_WORD;
      lit_ff   <= RST_WORD;
      word2_ff <= RST_WORD;
    end else if (wr_acc) begin
      unique case (paddr)
        ADR_CTRL: begin
          op_ff   <= lsbf_op_type'(pwdata[5:0]);
          form_ff <= lsbf_form_type'(pwdata[CTL_FORM_LO +: 2]);
          dstw_ff <= pwdata[CTL_DSTW];
          two_ff  <= pwdata[CTL_TWO];
          exc_ff  <= pwdata[CTL_EXC];
          cond_ff <= lsbf_cond_type'(pwdata[CTL_COND_LO +: 5]);
        end
        ADR_OPA:   opa_ff   <= pwdata[15:0];
        ADR_OPB:   opb_ff   <= pwdata[15:0];
        ADR_LIT:   lit_ff   <= pwdata[15:0];
        ADR_WORD2: word2_ff <= pwdata[15:0];
        default:   opa_ff   <= opa_ff;
      endcase
    end
  end

  // result destination: file register, default working register or destination register
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      freg_ff   <= RST_WORD;
      dwreg_ff  <= RST_WORD;
      result_ff <= RST_WORD;
    end else if (wr_acc && paddr == ADR_FREG) begin
      freg_ff <= pwdata[15:0];
    end else if (wr_acc && paddr == ADR_DWREG) begin
      dwreg_ff <= pwdata[15:0];
    end else if (exec && alu_wr) begin
      if (form_ff != FORM_FILE || op_ff == OP_RETL) result_ff <= alu_res;
      else if (dstw_ff) dwreg_ff <= alu_res;
      else freg_ff <= alu_res;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      flags_ff <= RST_FLAGS;
    end else if (wr_acc && paddr == ADR_STAT) begin
      flags_ff <= pwdata[7:0];
    end else if (exec && !(op_ff inside {OP_NOP, [OP_SKCL:OP_RETI]})) begin
      flags_ff[FLG_C]  <= alu_c;
      flags_ff[FLG_Z]  <= alu_z;
      flags_ff[FLG_N]  <= alu_n;
      flags_ff[FLG_OV] <= alu_v;
    end
  end

  // ----------------------------------------------------------------
  // APB slave: data captured in setup, zero-wait access phase
  // ----------------------------------------------------------------
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      ADR_CTRL:   rd_mux = {16'h0000, cond_ff, exc_ff, two_ff, dstw_ff, form_ff, op_ff};
      ADR_OPA:    rd_mux = {16'h0000, opa_ff};
      ADR_OPB:    rd_mux = {16'h0000, opb_ff};
      ADR_LIT:    rd_mux = {16'h0000, lit_ff};
      ADR_WORD2:  rd_mux = {16'h0000, word2_ff};
      ADR_FREG:   rd_mux = {16'h0000, freg_ff};
      ADR_DWREG:  rd_mux = {16'h0000, dwreg_ff};
      ADR_STAT:   rd_mux = {20'h00000, cycles_ff, taken_ff, (state_ff != ST_IDLE), flags_ff};
      ADR_RESULT: rd_mux = {16'h0000, result_ff};
      ADR_PC:     rd_mux = {16'h0000, pc_ff};
      ADR_LOOP:   rd_mux = {2'h0, rpt_ff, lp_cnt_ff};
      default:    rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      prdata_ff  <= 32'h0000_0000;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else if (psel && !penable) begin
      prdata_ff  <= pwrite ? 32'h0000_0000 : rd_mux;
      pready_ff  <= 1'b1;
      pslverr_ff <= !reg_hit(paddr);
    end else begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end
  end

  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;

endmodule : lsbf_exec

// ===== hdl/lsbf_pkg.sv
// constants, types and register map of the logic, shift, bit and flow execution block
// Behaviour
// - optional default operand redirects result from file
// - logic ops take four operand forms, one cycle
// - arithmetic right shift copies sign, literal/register amount
// - logical right and left shifts insert zeros
// - rotate through carry uses carry as extra bit
// - rotate without carry wraps end bit around
// - test-then-set copies bit to flag, then sets
// - flag bit write stores carry or inverted zero
// - register-indexed bit test copies bit to flag
// - bit scans find msb one, lsb one, sign change
// - compare zero updates flags, stores nothing
// - compare-skip subtracts and skips on chosen relation
// - skip costs one, two or three cycles
// - bit-test skip skips on clear or set bit
// - branches test accumulator overflow and saturation flags
// - jumps and calls take two cycles
// - hardware loop repeats body count plus one times
// - single repeat reruns next instruction count plus one
// - returns take three cycles, two if exception pending
// - return with literal loads ten-bit literal
// - branch costs one cycle not taken, two taken
package lsbf_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADR_CTRL   = 8'h00;
  localparam logic [7:0] ADR_OPA    = 8'h04;
  localparam logic [7:0] ADR_OPB    = 8'h08;
  localparam logic [7:0] ADR_LIT    = 8'h0c;
  localparam logic [7:0] ADR_WORD2  = 8'h10;
  localparam logic [7:0] ADR_FREG   = 8'h14;
  localparam logic [7:0] ADR_DWREG  = 8'h18;
  localparam logic [7:0] ADR_STAT   = 8'h1c;
  localparam logic [7:0] ADR_RESULT = 8'h20;
  localparam logic [7:0] ADR_PC     = 8'h24;
  localparam logic [7:0] ADR_LOOP   = 8'h28;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTL_FORM_LO = 6;
  localparam int CTL_DSTW    = 8;
  localparam int CTL_TWO     = 9;
  localparam int CTL_EXC     = 10;
  localparam int CTL_COND_LO = 11;
  localparam int CTL_GO      = 31;
  localparam int FLG_C       = 0;
  localparam int FLG_Z       = 1;
  localparam int FLG_N       = 2;
  localparam int FLG_OV      = 3;
  localparam int FLG_OA      = 4;
  localparam int FLG_OB      = 5;
  localparam int FLG_SA      = 6;
  localparam int FLG_SB      = 7;
  localparam int STA_BUSY    = 8;
  localparam int STA_TAKEN   = 9;
  localparam int STA_CYC_LO  = 10;

  // ----------------------------------------------------------------
  // reset values, data and scan constants and cycle counts
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_WORD  = 16'h0000;
  localparam logic [7:0]  RST_FLAGS = 8'h00;
  localparam logic [14:0] RST_CNT   = 15'h0000;
  localparam logic [15:0] VAL_ZERO  = 16'h0000;
  localparam logic [15:0] VAL_ONES  = 16'hffff;
  localparam logic [4:0]  SCAN_NONE = 5'h10;
  localparam logic [1:0]  CYC_ONE   = 2'h1;
  localparam logic [1:0]  CYC_TWO   = 2'h2;
  localparam logic [1:0]  CYC_THREE = 2'h3;

  typedef enum logic [5:0] {
    OP_NOP   = 6'h00, OP_AND   = 6'h01, OP_IOR   = 6'h02, OP_XOR  = 6'h03,
    OP_CLR   = 6'h04, OP_ONES  = 6'h05, OP_COM   = 6'h06, OP_ARSH = 6'h07,
    OP_LRSH  = 6'h08, OP_LSH   = 6'h09, OP_RLCY  = 6'h0a, OP_RLNC = 6'h0b,
    OP_RRCY  = 6'h0c, OP_ROTATE_RIGHT_NOCARRY  = 6'h0d, OP_BSET  = 6'h0e, OP_BCLR = 6'h0f,
    OP_BTGL  = 6'h10, OP_BTSTC = 6'h11, OP_BTSTZ = 6'h12, OP_TSSC = 6'h13,
    OP_TSSZ  = 6'h14, OP_FBWC  = 6'h15, OP_FBWZ  = 6'h16, OP_SCHG = 6'h17,
    OP_SONEM = 6'h18, OP_SONEL = 6'h19, OP_CPZ   = 6'h1a, OP_CSEQ = 6'h1b,
    OP_CSGT  = 6'h1c, OP_CSLT  = 6'h1d, OP_CSNE  = 6'h1e, OP_SKCL = 6'h1f,
    OP_SKST  = 6'h20, OP_BRA   = 6'h21, OP_JMP   = 6'h22, OP_CALL = 6'h23,
    OP_RCALL = 6'h24, OP_LOOP  = 6'h25, OP_RPT   = 6'h26, OP_RET  = 6'h27,
    OP_RETL  = 6'h28, OP_RETI  = 6'h29
  } lsbf_op_type;

  typedef enum logic [4:0] {
    CC_ALW = 5'h00, CC_C   = 5'h01, CC_GE  = 5'h02, CC_GEU = 5'h03, CC_GT  = 5'h04,
    CC_GTU = 5'h05, CC_LE  = 5'h06, CC_LEU = 5'h07, CC_LT  = 5'h08, CC_LTU = 5'h09,
    CC_N   = 5'h0a, CC_NC  = 5'h0b, CC_NN  = 5'h0c, CC_NOV = 5'h0d, CC_NZ  = 5'h0e,
    CC_OA  = 5'h0f, CC_OB  = 5'h10, CC_OV  = 5'h11, CC_SA  = 5'h12, CC_SB  = 5'h13,
    CC_Z   = 5'h14
  } lsbf_cond_type;

  typedef enum logic [1:0] {
    FORM_FILE = 2'b00, FORM_LIT10 = 2'b01, FORM_SHORT = 2'b10, FORM_REG = 2'b11
  } lsbf_form_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_EXEC = 2'b01, ST_WAIT = 2'b10
  } lsbf_state_type;

  typedef enum logic [1:0] {
    SCAN_MSB1 = 2'b00, SCAN_LSB1 = 2'b01, SCAN_SIGN = 2'b10
  } lsbf_scan_type;

endpackage : lsbf_pkg

// ===== hdl/lsbf_scan.sv
// bit scan unit: first one from either end, first change from sign
`timescale 1ns/1ps
module lsbf_scan import lsbf_pkg::*; (
  input  wire logic [15:0]   val,
  input  wire lsbf_scan_type mode,
  output logic [4:0]         pos
);
  logic hit;
  logic [3:0] idx;

  always_comb begin
    pos = SCAN_NONE;
    hit = 1'b0;
    idx = 4'h0;
    for (int k = 0; k < 16; k++) begin
      idx = (mode == SCAN_LSB1) ? 4'(k) : 4'(15 - k);
      if (!hit) begin
        if ((mode != SCAN_SIGN && val[idx]) ||
            (mode == SCAN_SIGN && idx != 4'hf && val[idx] != val[15])) begin
          pos = {1'b0, idx};
          hit = 1'b1;
        end
      end
    end
  end
endmodule : lsbf_scan

// ===== hdl/lsbf_alu.sv
// data operation unit for logic, shift, rotate, bit and compare operations
`timescale 1ns/1ps
module lsbf_alu import lsbf_pkg::*; (
  input  wire lsbf_op_type op,
  input  wire logic [15:0] a,
  input  wire logic [15:0] b,
  input  wire logic [3:0]  amt,
  input  wire logic [3:0]  bidx,
  input  wire logic [4:0]  scan_pos,
  input  wire logic        c_in,
  input  wire logic        z_in,
  output logic [15:0]      res,
  output logic             wr,
  output logic             c_out,
  output logic             z_out,
  output logic             n_out,
  output logic             v_out
);
  logic [16:0] diff;
  logic [15:0] bmask;
  logic [15:0] shr;

  always_comb begin
    bmask = 16'h0001 << bidx;
    diff  = {1'b0, a} - {1'b0, (op == OP_CPZ) ? VAL_ZERO : b};
    shr   = a >> (amt - 4'h1);
    res   = a;
    wr    = 1'b1;
    c_out = c_in;
    z_out = z_in;
    unique case (op)
      OP_AND:   res = a & b;
      OP_IOR:   res = a | b;
      OP_XOR:   res = a ^ b;
      OP_CLR:   res = VAL_ZERO;
      OP_ONES:  res = VAL_ONES;
      OP_COM:   res = ~a;
      OP_ARSH: begin
        res   = 16'($signed(a) >>> amt);
        c_out = (amt == 4'h0) ? c_in : shr[0];
      end
      OP_LRSH: begin
        res   = a >> amt;
        c_out = (amt == 4'h0) ? c_in : shr[0];
      end
      OP_LSH: begin
        res   = a << amt;
        c_out = (amt == 4'h1) ? a[15] : c_in;
      end
      OP_RLCY: begin
        res   = {a[14:0], c_in};
        c_out = a[15];
      end
      OP_RRCY: begin
        res   = {c_in, a[15:1]};
        c_out = a[0];
      end
      OP_RLNC:  res = {a[14:0], a[15]};
      OP_ROTATE_RIGHT_NOCARRY:  res = {a[0], a[15:1]};
      OP_BSET:  res = a | bmask;
      OP_BCLR:  res = a & ~bmask;
      OP_BTGL:  res = a ^ bmask;
      OP_BTSTC: begin
        wr    = 1'b0;
        c_out = a[bidx];
      end
      OP_BTSTZ: begin
        wr    = 1'b0;
        z_out = ~a[bidx];
      end
      OP_TSSC: begin
        c_out = a[bidx];
        res   = a | bmask;
      end
      OP_TSSZ: begin
        z_out = ~a[bidx];
        res   = a | bmask;
      end
      OP_FBWC:  res = c_in ? (a | bmask) : (a & ~bmask);
      OP_FBWZ:  res = z_in ? (a & ~bmask) : (a | bmask);
      OP_SCHG, OP_SONEM, OP_SONEL: res = {11'h000, scan_pos};
      OP_CPZ, OP_CSEQ, OP_CSGT, OP_CSLT, OP_CSNE: begin
        wr    = 1'b0;
        c_out = ~diff[16];
      end
      OP_RETL:  res = {6'h00, b[9:0]};
      default:  wr = 1'b0;
    endcase
    if (op inside {OP_CPZ, OP_CSEQ, OP_CSGT, OP_CSLT, OP_CSNE}) begin
      z_out = (diff[15:0] == VAL_ZERO);
      n_out = diff[15];
      v_out = (a[15] ^ b[15]) & (a[15] ^ diff[15]) & (op != OP_CPZ);
    end else begin
      if (wr && !(op inside {OP_TSSZ, OP_FBWC, OP_FBWZ})) z_out = (res == VAL_ZERO);
      n_out = res[15];
      v_out = 1'b0;
    end
  end
endmodule : lsbf_alu

// ===== bench/lsbf_exec_sva.sv
// apb port checker for the execution block
`timescale 1ns/1ps
module lsbf_exec_sva import lsbf_pkg::*; (
  input wire logic        sys_clk,
  input wire logic        nrst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr
);
  // --
  // answer phase
  // --
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  wire logic hole = paddr > ADR_LOOP;
  sequence setup_s; psel && !penable; endsequence
  sequence access_s; psel && penable; endsequence
  a_ready_access: assert property (setup_s ##1 access_s |-> pready) else $error("no ready");
  a_ready_only: assert property (pready |-> psel && penable && $past(psel && !penable)) else $error("stray ready");
  a_ready_once: assert property (pready |=> !pready) else $error("ready held");
  a_err_hole: assert property (pready && hole |-> pslverr) else $error("no error");
  a_err_mapped: assert property (pready && !hole && paddr[1:0] == 2'h0 |-> !pslverr) else $error("bad error");
  a_err_quiet: assert property (!pready |-> !pslverr) else $error("loose error");
  a_read_hole: assert property (pready && hole && !pwrite |-> prdata == 32'h0) else $error("hole data");
  a_read_upper: assert property (pready && !pwrite && paddr != ADR_LOOP |-> prdata[31:16] == 16'h0) else $error("upper");
endmodule : lsbf_exec_sva

// ===== bench/lsbf_exec_tb.sv
// self-checking bench for the execution block
`timescale 1ns/1ps
module lsbf_exec_tb import lsbf_pkg::*; ;
  logic        sys_clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0, seed = 32'hc4ac, prdata, rd_val;
  logic        pready, pslverr;
  logic [15:0] a, b, y;
  int          miscompares = 0, checks_done = 0;
  lsbf_op_type dops [8] = '{OP_AND, OP_IOR, OP_XOR, OP_ARSH, OP_LRSH, OP_LSH, OP_CLR, OP_ONES};
  lsbf_op_type cops [9] = '{OP_CSEQ, OP_CSEQ, OP_CSNE, OP_BRA, OP_BRA, OP_BRA, OP_RET, OP_RET, OP_CALL};
  logic [7:0]  cxs [9]  = '{8'h00, 8'h02, 8'h00, 8'h00, 8'ha0, 8'h70, 8'h00, 8'h04, 8'h00};
  logic [1:0]  cyc [9]  = '{2'h2, 2'h3, 2'h1, 2'h2, 2'h1, 2'h2, 2'h3, 2'h2, 2'h2};
  lsbf_exec i_lsbf_exec (.sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  // --
  // helpers
  // --
  function logic [15:0] rnd16();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[15:0];
  endfunction : rnd16
  function logic [15:0] model(lsbf_op_type op, logic [15:0] x, logic [15:0] s);
    case (op)
      OP_AND:  return x & s;
      OP_IOR:  return x | s;
      OP_XOR:  return x ^ s;
      OP_ARSH: return 16'($signed(x) >>> s[3:0]);
      OP_LRSH: return x >> s[3:0];
      OP_LSH:  return x << s[3:0];
      OP_CLR:  return VAL_ZERO;
      default: return VAL_ONES;
    endcase
  endfunction : model
  function logic [31:0] cw(lsbf_op_type op, lsbf_form_type f, logic [7:0] x);
    return {1'b1, 15'h0, x, f, op};
  endfunction : cw
  task stop_test();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge sys_clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= ad;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd_val = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task rd(input logic [7:0] ad, input logic [31:0] exp);
    apb(1'b0, ad, 32'h0);
    chk(rd_val, exp);
  endtask : rd
  // leaves the last status word in rd_val
  task run(input logic [31:0] ctl);
    apb(1'b1, ADR_CTRL, ctl);
    do apb(1'b0, ADR_STAT, 32'h0); while (rd_val[STA_BUSY] !== 1'b0);
  endtask : run
  initial begin
    repeat (12) @(posedge sys_clk);
    nrst <= 1'b1;
    for (int i = 0; i <= 11; i++) rd(8'(i * 4), 32'h0);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      a = (i == 0) ? 16'h8001 : rnd16();
      b = (i == 0) ? 16'hffff : rnd16();
      apb(1'b1, ADR_OPA, {16'h0, a});
      apb(1'b1, ADR_LIT, {28'h0, b[3:0]});
      foreach (dops[k]) for (int f = 2; f < 4; f++) begin
        y = (f == 3 && dops[k] < OP_ARSH) ? b : {12'h0, b[3:0]};
        apb(1'b1, ADR_OPB, {16'h0, y});
        run(cw(dops[k], lsbf_form_type'(f), 8'h00));
        rd(ADR_RESULT, {16'h0, model(dops[k], a, y)});
      end
    end
    $display("test data ops done");
    apb(1'b1, ADR_FREG, {16'h0, a});
    apb(1'b1, ADR_DWREG, {16'h0, b});
    run(cw(OP_AND, FORM_FILE, 8'h01));
    rd(ADR_DWREG, {16'h0, a & b});
    rd(ADR_FREG, {16'h0, a});
    run(cw(OP_XOR, FORM_FILE, 8'h00));
    rd(ADR_FREG, {16'h0, a ^ (a & b)});
    apb(1'b1, ADR_FREG, {16'h0, a});
    apb(1'b1, ADR_STAT, 32'h1);
    run(cw(OP_RLCY, FORM_FILE, 8'h00));
    chk({31'h0, rd_val[FLG_C]}, {31'h0, a[15]});
    rd(ADR_FREG, {16'h0, a[14:0], 1'b1});
    run(cw(OP_ROTATE_RIGHT_NOCARRY, FORM_FILE, 8'h00));
    rd(ADR_FREG, {16'h0, 1'b1, a[14:0]});
    $display("test file forms done");
    apb(1'b1, ADR_OPB, {16'h0, a});
    foreach (cops[k]) begin
      apb(1'b1, ADR_STAT, 32'h0);
      run(cw(cops[k], FORM_REG, cxs[k]));
      chk({30'h0, rd_val[11:10]}, {30'h0, cyc[k]});
    end
    apb(1'b1, ADR_STAT, 32'h80);
    run(cw(OP_BRA, FORM_REG, 8'h98));
    chk({30'h0, rd_val[11:10]}, {30'h0, CYC_TWO});
    $display("test cycle costs done");
    apb(1'b1, ADR_OPA, 32'hf140);
    run(cw(OP_SONEM, FORM_REG, 8'h00));
    rd(ADR_RESULT, 32'hf);
    run(cw(OP_SONEL, FORM_REG, 8'h00));
    rd(ADR_RESULT, 32'h6);
    run(cw(OP_SCHG, FORM_REG, 8'h00));
    rd(ADR_RESULT, 32'hb);
    apb(1'b1, ADR_LIT, 32'hffff);
    run(cw(OP_RETL, FORM_LIT10, 8'h00));
    rd(ADR_RESULT, 32'h3ff);
    apb(1'b1, ADR_FREG, {16'h0, a});
    apb(1'b1, ADR_LIT, 32'h5);
    run(cw(OP_TSSC, FORM_FILE, 8'h00));
    chk({31'h0, rd_val[FLG_C]}, {31'h0, a[5]});
    rd(ADR_FREG, {16'h0, a | 16'h0020});
    apb(1'b1, ADR_FREG, {16'h0, a});
    apb(1'b1, ADR_LIT, 32'h11);
    run(cw(OP_RPT, FORM_SHORT, 8'h00));
    run(cw(OP_RLNC, FORM_FILE, 8'h00));
    rd(ADR_FREG, {16'h0, a[13:0], a[15:14]});
    $display("test bits done");
    stop_test();
  end
  initial begin
    repeat (60000) @(posedge sys_clk);
    miscompares++;
    stop_test();
  end
endmodule : lsbf_exec_tb
bind lsbf_exec lsbf_exec_sva i_lsbf_exec_sva (.sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
